// ===== design/awh_map.svh
// constants of the sector write command handler
//
// Contract
// - CDh runs as block multiple write but skips the implied erase; the code still erases when the sector is not blank.
// - 30h/31h write 1 to 256 sectors from count, zero meaning 256.
// - write starts at sector number plus cylinder/head or LBA fields.
// - on accept set BSY, then set DRQ, clear BSY, wait for data.
// - no interrupt is raised for the first sector's transfer.
// - after each sector set BSY, clear DRQ; next buffer: DRQ plus interrupt.
// - after last sector hold BSY until done, then clear BSY, interrupt.
// - on error stop at failing sector, keep its address in registers.
// - 38h skips the erase but erases anyway when sector is not blank.
// - 3Ch verifies each sector right after writing it.
// - feature register selects the SMART subcommand.
// - SMART with unsupported feature value is aborted.
// - block multiple write aborts unless block size set and enabled.
// - block size is one sector, one sector between interrupts.
// - BSY within 400 ns of accepting a block multiple write.
`ifndef AWH_MAP_SVH
`define AWH_MAP_SVH

// task-file register index
`define AWH_TF_DATA   3'h0
`define AWH_TF_FEAT   3'h1
`define AWH_TF_COUNT  3'h2
`define AWH_TF_SECN   3'h3
`define AWH_TF_CYLLO  3'h4
`define AWH_TF_CYLHI  3'h5
`define AWH_TF_DH     3'h6
`define AWH_TF_CMD    3'h7

// opcodes
`define AWH_OP_WR0      8'h30
`define AWH_OP_WR1      8'h31
`define AWH_OP_WR_NOER  8'h38
`define AWH_OP_WR_VFY   8'h3C
`define AWH_OP_MULT     8'hC5
`define AWH_OP_MULT_NOE 8'hCD
`define AWH_OP_SETMULT  8'hC6
`define AWH_OP_SMART    8'hB0

// smart subcommands
`define AWH_SM_RDATA  8'hD0
`define AWH_SM_RTHR   8'hD1
`define AWH_SM_ASAVE  8'hD2
`define AWH_SM_ENA    8'hD8
`define AWH_SM_DIS    8'hD9
`define AWH_SM_STAT   8'hDA

// status and error bits
`define AWH_ST_BSY   7
`define AWH_ST_DRDY  6
`define AWH_ST_DSC   4
`define AWH_ST_DRQ   3
`define AWH_ST_ERR   0
`define AWH_ER_MEDIA 8'h40
`define AWH_ER_ABRT  8'h04

// drive/head fields
`define AWH_DH_LBA   6
`define AWH_DH_DRV   4
`define AWH_DH_FIXED 8'hA0

// geometry, sector size, block size
`define AWH_WORDS    256
`define AWH_SPT      8'd63
`define AWH_HEADS    4'd15
`define AWH_BLOCK    8'h01

// busy latency
`define AWH_T_BSY_NS  400
`define AWH_CLK_NS    10
`define AWH_BSY_CYC   (`AWH_T_BSY_NS / `AWH_CLK_NS)

`endif

// ===== design/awh_pkg.sv
// types of the sector write command handler
package awh_pkg;

  typedef enum logic [2:0] {
    ST_IDLE   = 3'b000,
    ST_ACCEPT = 3'b001,
    ST_XFER   = 3'b010,
    ST_PROG   = 3'b011,
    ST_WAIT   = 3'b100
  } awh_state_t;

  typedef enum logic [2:0] {
    K_WRITE   = 3'b000,
    K_NOERASE = 3'b001,
    K_VERIFY  = 3'b010,
    K_MULTI   = 3'b011,
    K_MULTI_N = 3'b100,
    K_SETMULT = 3'b101,
    K_SMART   = 3'b110,
    K_BAD     = 3'b111
  } awh_kind_t;

endpackage

// ===== design/awh_addr_step.sv
// next sector address in chs or lba mode
`timescale 1ns/10ps
`default_nettype none
`include "awh_map.svh"

module awh_addr_step (
  input  wire logic        lba_mode,
  input  wire logic [3:0]  head_in,
  input  wire logic [15:0] cyl_in,
  input  wire logic [7:0]  sec_in,
  output logic      [3:0]  head_out,
  output logic      [15:0] cyl_out,
  output logic      [7:0]  sec_out
);

  // lba: one 28-bit count over head, cylinder and sector
  wire [27:0] lba_next = {head_in, cyl_in, sec_in} + 28'h0000001;
  wire        sec_wrap = (sec_in == `AWH_SPT);
  wire        head_wrap = (head_in == `AWH_HEADS);

  // chs: sector 1..spt, then head, then cylinder
  wire [7:0]  chs_sec = sec_wrap ? 8'h01 : sec_in + 8'h01;
  wire [3:0]  chs_head = !sec_wrap ? head_in :
                         head_wrap ? 4'h0 : head_in + 4'h1;
  wire [15:0] chs_cyl = (sec_wrap && head_wrap) ? cyl_in + 16'h0001
                                               : cyl_in;

  assign sec_out  = lba_mode ? lba_next[7:0]   : chs_sec;
  assign cyl_out  = lba_mode ? lba_next[23:8]  : chs_cyl;
  assign head_out = lba_mode ? lba_next[27:24] : chs_head;

endmodule // awh_addr_step
`default_nettype wire

// ===== design/awh_write_handler.sv
// sector write command handler behind the task-file registers
`timescale 1ns/10ps
`default_nettype none
`include "awh_map.svh"

module awh_write_handler (
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic [2:0]  tf_addr,
  input  wire logic        tf_wr,
  input  wire logic        tf_rd,
  input  wire logic [15:0] tf_wdata,
  output logic      [15:0] tf_rdata,
  output logic             intrq,
  output logic             busy,
  output logic             drq,
  output logic             media_req,
  output logic             media_lba_mode,
  output logic             media_drive,
  output logic      [3:0]  media_head,
  output logic      [15:0] media_cyl,
  output logic      [7:0]  media_sec,
  output logic             media_erase,
  output logic             media_verify,
  input  wire logic        media_blank,
  input  wire logic [7:0]  media_raddr,
  output logic      [15:0] media_rdata,
  input  wire logic        media_done,
  input  wire logic        media_err,
  output logic             smart_enabled
);
  import awh_pkg::*;

  // sector buffer, filled by host, drained by media
  logic [15:0] sbuf [0:`AWH_WORDS-1];

  logic [7:0]  feat_q, count_q, secn_q, cyllo_q, cylhi_q, dh_q;
  logic [7:0]  err_q;
  logic        errst_q;
  logic        intrq_q;
  logic [7:0]  op_q;
  awh_kind_t   kind_q;
  logic        ok_q;
  awh_state_t  state_q, state_d;
  logic [8:0]  left_q;
  logic [7:0]  wptr_q;
  logic        multi_q;
  logic        smart_q;
  logic        mreq_q, erase_q, verify_q;
  logic [15:0] rdata_q, mrdata_q;
  logic [3:0]  nx_head;
  logic [15:0] nx_cyl;
  logic [7:0]  nx_sec;
  logic        is_xfer_q;
  logic [3:0]  head_q;

  // opcode classification
  function automatic awh_kind_t kind_of(input logic [7:0] op);
    if (op == `AWH_OP_WR0 || op == `AWH_OP_WR1)
      return K_WRITE;
    else if (op == `AWH_OP_WR_NOER)
      return K_NOERASE;
    else if (op == `AWH_OP_WR_VFY)
      return K_VERIFY;
    else if (op == `AWH_OP_MULT)
      return K_MULTI;
    else if (op == `AWH_OP_MULT_NOE)
      return K_MULTI_N;
    else if (op == `AWH_OP_SETMULT)
      return K_SETMULT;
    else if (op == `AWH_OP_SMART)
      return K_SMART;
    else
      return K_BAD;
  endfunction

  // smart subcommand check
  function automatic logic smart_ok(input logic [7:0] f);
    return f == `AWH_SM_RDATA || f == `AWH_SM_RTHR ||
           f == `AWH_SM_ASAVE || f == `AWH_SM_ENA ||
           f == `AWH_SM_DIS   || f == `AWH_SM_STAT;
  endfunction

  // host access decode
  wire        in_idle  = (state_q == ST_IDLE);
  wire        in_xfer  = (state_q == ST_XFER);
  wire        tf_write = tf_wr && in_idle;
  wire        cmd_wr   = tf_write && tf_addr == `AWH_TF_CMD;
  wire        data_wr  = tf_wr && in_xfer && tf_addr == `AWH_TF_DATA;
  wire        stat_rd  = tf_rd && tf_addr == `AWH_TF_CMD;
  wire [7:0]  new_op   = tf_wdata[7:0];
  wire awh_kind_t new_kind = kind_of(new_op);

  // verdict on the new command
  wire is_xfer_kind = new_kind == K_WRITE || new_kind == K_NOERASE ||
                      new_kind == K_VERIFY || new_kind == K_MULTI ||
                      new_kind == K_MULTI_N;
  wire is_multi     = new_kind == K_MULTI || new_kind == K_MULTI_N;
  wire multi_bad    = is_multi && !multi_q;
  wire setm_bad     = new_kind == K_SETMULT && count_q != 8'h00 &&
                      count_q != `AWH_BLOCK;
  wire smart_bad    = new_kind == K_SMART && !smart_ok(feat_q);
  wire new_ok       = !(new_kind == K_BAD || multi_bad ||
                        setm_bad || smart_bad);

  // sector progress
  wire sector_full  = data_wr && wptr_q == 8'hFF;
  wire last_sector  = left_q == 9'd1;
  wire good_done    = state_q == ST_WAIT && media_done && !media_err;
  wire bad_done     = state_q == ST_WAIT && media_done && media_err;
  wire no_erase     = kind_q == K_NOERASE || kind_q == K_MULTI_N;
  wire accept_end   = state_q == ST_ACCEPT && !(ok_q && is_xfer_q);

  // completion and next-buffer events raise the interrupt
  wire irq_set = accept_end || bad_done ||
                 (good_done && !last_sector) ||
                 (good_done && last_sector);

  // status image
  assign busy = state_q == ST_ACCEPT || state_q == ST_PROG ||
                state_q == ST_WAIT;
  assign drq  = in_xfer;
  wire [7:0] status = {busy, !busy, 1'b0, 1'b1, drq, 2'b00, errst_q};

  // register read mux
  wire [7:0] rd_byte =
    tf_addr == `AWH_TF_FEAT  ? err_q   :
    tf_addr == `AWH_TF_COUNT ? count_q :
    tf_addr == `AWH_TF_SECN  ? secn_q  :
    tf_addr == `AWH_TF_CYLLO ? cyllo_q :
    tf_addr == `AWH_TF_CYLHI ? cylhi_q :
    tf_addr == `AWH_TF_DH    ? {dh_q[7:4], head_q} :
    tf_addr == `AWH_TF_CMD   ? status  : 8'h00;

  // next sector address
  awh_addr_step u_step (
    .lba_mode (dh_q[`AWH_DH_LBA]),
    .head_in  (head_q),
    .cyl_in   ({cylhi_q, cyllo_q}),
    .sec_in   (secn_q),
    .head_out (nx_head),
    .cyl_out  (nx_cyl),
    .sec_out  (nx_sec)
  );

  // command state machine
  always_comb begin
    state_d = state_q;
    case (state_q)
      ST_IDLE:   if (cmd_wr) state_d = ST_ACCEPT;
      ST_ACCEPT: state_d = (ok_q && is_xfer_q) ? ST_XFER : ST_IDLE;
      ST_XFER:   if (sector_full) state_d = ST_PROG;
      ST_PROG:   state_d = ST_WAIT;
      ST_WAIT: begin
        if (bad_done || (good_done && last_sector))
          state_d = ST_IDLE;
        else if (good_done)
          state_d = ST_XFER;
      end
      default:   state_d = ST_IDLE;
    endcase
  end

  always_ff @(posedge clk) begin
    if (!rst_n) state_q <= ST_IDLE;
    else        state_q <= state_d;
  end

  // latched command
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      op_q <= 8'h00;
      kind_q <= K_BAD;
      ok_q <= 1'b0;
      is_xfer_q <= 1'b0;
    end else if (cmd_wr) begin
      op_q <= new_op;
      kind_q <= new_kind;
      ok_q <= new_ok;
      is_xfer_q <= is_xfer_kind;
    end
  end

  // feature and drive/head registers, host written while idle
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      feat_q <= 8'h00;
      dh_q <= `AWH_DH_FIXED;
    end else if (tf_write) begin
      if (tf_addr == `AWH_TF_FEAT) feat_q <= tf_wdata[7:0];
      if (tf_addr == `AWH_TF_DH)
        dh_q <= tf_wdata[7:0] | `AWH_DH_FIXED;
    end
  end

  // count and address: host writes, device steps per sector
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      count_q <= 8'h01;
      secn_q <= 8'h01;
      cyllo_q <= 8'h00;
      cylhi_q <= 8'h00;
    end else if (tf_write) begin
      if (tf_addr == `AWH_TF_COUNT) count_q <= tf_wdata[7:0];
      if (tf_addr == `AWH_TF_SECN)  secn_q <= tf_wdata[7:0];
      if (tf_addr == `AWH_TF_CYLLO) cyllo_q <= tf_wdata[7:0];
      if (tf_addr == `AWH_TF_CYLHI) cylhi_q <= tf_wdata[7:0];
    end else if (good_done) begin
      count_q <= count_q - 8'h01; // residual count
      if (!last_sector) begin
        secn_q <= nx_sec;
        cyllo_q <= nx_cyl[7:0];
        cylhi_q <= nx_cyl[15:8];
      end
    end
  end

  // head bits follow the sector step
  always_ff @(posedge clk) begin
    if (!rst_n)
      head_q <= 4'h0;
    else if (tf_write && tf_addr == `AWH_TF_DH)
      head_q <= tf_wdata[3:0];
    else if (good_done && !last_sector)
      head_q <= nx_head;
  end

  // sectors still to go, zero count meaning 256
  always_ff @(posedge clk) begin
    if (!rst_n)
      left_q <= 9'd0;
    else if (cmd_wr)
      left_q <= (count_q == 8'h00) ? 9'd256 : {1'b0, count_q};
    else if (good_done)
      left_q <= left_q - 9'd1;
  end

  // block size and smart state
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      multi_q <= 1'b0;
      smart_q <= 1'b0;
    end else if (state_q == ST_ACCEPT && ok_q) begin
      if (kind_q == K_SETMULT)
        multi_q <= count_q == `AWH_BLOCK;
      if (kind_q == K_SMART && feat_q == `AWH_SM_ENA)
        smart_q <= 1'b1;
      if (kind_q == K_SMART && feat_q == `AWH_SM_DIS)
        smart_q <= 1'b0;
    end
  end

  // error register and error status bit
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      err_q <= 8'h00;
      errst_q <= 1'b0;
    end else if (cmd_wr) begin
      err_q <= 8'h00;
      errst_q <= 1'b0;
    end else if (state_q == ST_ACCEPT && !ok_q) begin
      err_q <= `AWH_ER_ABRT;
      errst_q <= 1'b1;
    end else if (bad_done) begin
      err_q <= `AWH_ER_MEDIA;
      errst_q <= 1'b1;
    end
  end

  // interrupt: set wins over the status-read clear
  always_ff @(posedge clk) begin
    if (!rst_n)
      intrq_q <= 1'b0;
    else if (irq_set)
      intrq_q <= 1'b1;
    else if (stat_rd || cmd_wr)
      intrq_q <= 1'b0;
  end

  // host word fill pointer
  always_ff @(posedge clk) begin
    if (!rst_n)
      wptr_q <= 8'h00;
    else if (state_q != ST_XFER)
      wptr_q <= 8'h00;
    else if (data_wr)
      wptr_q <= wptr_q + 8'h01;
  end

  // buffer write by host, read by media
  always_ff @(posedge clk) begin
    if (data_wr) sbuf[wptr_q] <= tf_wdata;
    mrdata_q <= sbuf[media_raddr];
  end

  // media request with erase and verify choice
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      mreq_q <= 1'b0;
      erase_q <= 1'b1;
      verify_q <= 1'b0;
    end else begin
      mreq_q <= state_q == ST_PROG;
      if (state_q == ST_PROG) begin
        erase_q <= !no_erase || !media_blank;
        verify_q <= kind_q == K_VERIFY;
      end
    end
  end

  // registered read data
  always_ff @(posedge clk) begin
    if (!rst_n)
      rdata_q <= 16'h0000;
    else if (tf_rd)
      rdata_q <= {8'h00, rd_byte};
  end

  assign tf_rdata       = rdata_q;
  assign intrq          = intrq_q;
  assign media_req      = mreq_q;
  assign media_rdata    = mrdata_q;
  assign media_erase    = erase_q;
  assign media_verify   = verify_q;
  assign media_lba_mode = dh_q[`AWH_DH_LBA];
  assign media_drive    = dh_q[`AWH_DH_DRV];
  assign media_head     = head_q;
  assign media_cyl      = {cylhi_q, cyllo_q};
  assign media_sec      = secn_q;
  assign smart_enabled  = smart_q;

endmodule // awh_write_handler
`default_nettype wire

// ===== test/awh_checker.sv
// port assertions for the sector write handler
`timescale 1ns/10ps
`default_nettype none

module awh_checker (
  input wire logic        clk,
  input wire logic        rst_n,
  input wire logic [2:0]  tf_addr,
  input wire logic        tf_wr,
  input wire logic        tf_rd,
  input wire logic [15:0] tf_wdata,
  input wire logic        intrq,
  input wire logic        busy,
  input wire logic        drq,
  input wire logic        media_req,
  input wire logic        media_erase,
  input wire logic        media_verify,
  input wire logic        media_blank,
  input wire logic        media_done,
  input wire logic        media_err
);
  logic [7:0] op_q;
  logic       cmd;
  logic       wr_op;
  logic       no_er;

  // command taken while idle, and its kind
  assign cmd = tf_wr && tf_addr == 3'h7 && !busy && !drq;
  assign wr_op = tf_wdata[7:0] inside {8'h30, 8'h31, 8'h38, 8'h3C};
  assign no_er = (op_q == 8'h38 || op_q == 8'hCD) && media_blank;

  // opcode of the running command
  always_ff @(posedge clk) begin
    if (!rst_n) op_q <= 8'h00;
    else if (cmd) op_q <= tf_wdata[7:0];
  end

  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);

  a_cmd_busy_drq: assert property (
    cmd && wr_op |=> busy ##1 (drq && !busy && !intrq))
    else $error("write command handshake wrong");
  a_busy_drq_excl: assert property (
    !(busy && drq)) else $error("busy and drq together");
  a_req_busy: assert property (
    media_req |-> busy && !drq) else $error("program request not busy");
  a_done_next: assert property (
    media_done && busy && !media_err |=> intrq && !busy)
    else $error("sector end without interrupt");
  a_err_stop: assert property (
    media_done && busy && media_err |=> !busy && !drq && intrq)
    else $error("failing sector did not stop");
  a_erase_mode: assert property (
    media_done && busy |-> media_erase == !no_er)
    else $error("erase choice wrong");
  a_verify_mode: assert property (
    media_done && busy |-> media_verify == (op_q == 8'h3C))
    else $error("verify choice wrong");
  a_irq_clear: assert property (
    tf_rd && tf_addr == 3'h7 && !busy |=> !intrq)
    else $error("status read kept interrupt");
endmodule // awh_checker

bind awh_write_handler awh_checker u_chk (.clk, .rst_n, .tf_addr, .tf_wr,
  .tf_rd, .tf_wdata, .intrq, .busy, .drq, .media_req, .media_erase,
  .media_verify, .media_blank, .media_done, .media_err);

`default_nettype wire

// ===== test/awh_host_model.sv
// host controller model driving the task-file strobes
`timescale 1ns/10ps
`default_nettype none

module awh_host_model (
  input  wire logic        clk,
  input  wire logic        busy,
  input  wire logic        drq,
  input  wire logic        intrq,
  input  wire logic [15:0] tf_rdata,
  output logic      [2:0]  tf_addr,
  output logic             tf_wr,
  output logic             tf_rd,
  output logic      [15:0] tf_wdata
);
  // bus idle at time zero
  initial begin
    tf_addr = 3'h0;
    tf_wr = 1'b0;
    tf_rd = 1'b0;
    tf_wdata = 16'h0000;
  end

  // one write, strobe held over one rising edge
  task automatic wr(input logic [2:0] a, input logic [15:0] d);
    @(negedge clk);
    tf_addr = a;
    tf_wdata = d;
    tf_wr = 1'b1;
    @(negedge clk);
    tf_wr = 1'b0;
    tf_wdata = ~d; // released bus shows no stale data
  endtask

  // one read, data taken once settled
  task automatic rd(input logic [2:0] a, output logic [15:0] d);
    @(negedge clk);
    tf_addr = a;
    tf_rd = 1'b1;
    @(negedge clk);
    tf_rd = 1'b0;
    @(negedge clk);
    d = tf_rdata;
  endtask

  // one sector, sent only once busy is clear and drq set
  task automatic sector(input logic [7:0] g, output logic ok,
                        output logic q);
    int          n;
    logic [15:0] s;
    n = 0;
    while (!(drq === 1'b1 && busy === 1'b0) && n < 2000) begin
      @(negedge clk);
      n++;
    end
    ok = n < 2000;
    q = intrq;
    if (intrq === 1'b1) rd(3'h7, s);
    if (ok) for (int i = 0; i < 256; i++) wr(3'h0, {g, i[7:0]});
  endtask
endmodule // awh_host_model

`default_nettype wire

// ===== test/awh_write_handler_bench.sv
// self-checking bench of the sector write handler
`timescale 1ns/10ps
`default_nettype none

module awh_write_handler_bench;
  logic        clk, rst_n, tf_wr, tf_rd, intrq, busy, drq, media_req;
  logic        media_lba_mode, media_erase, media_verify, media_blank;
  logic        media_done, media_err, smart_enabled, ok, media_drive;
  logic [2:0]  tf_addr;
  logic [3:0]  media_head;
  logic [7:0]  media_sec, media_raddr, exp_tag;
  logic [15:0] tf_wdata, tf_rdata, media_cyl, media_rdata, rv;
  logic [27:0] exp_addr;
  int          mismatches, check_count, cycles, err_at, done_n;

  awh_write_handler dut (.clk, .rst_n, .tf_addr, .tf_wr, .tf_rd,
    .tf_wdata, .tf_rdata, .intrq, .busy, .drq, .media_req, .media_lba_mode,
    .media_drive, .media_head, .media_cyl, .media_sec, .media_erase,
    .media_verify, .media_blank, .media_raddr, .media_rdata, .media_done,
    .media_err, .smart_enabled);
  awh_host_model host (.clk, .busy, .drq, .intrq, .tf_rdata, .tf_addr,
    .tf_wr, .tf_rd, .tf_wdata);

  // clock and hang limit
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      mismatches++;
      end_of_test();
    end
  end

  // flash side: check address, first and last word, answer later
  always @(negedge clk) begin
    if (media_req === 1'b1) begin
      chk({media_head, media_cyl, media_sec}, exp_addr);
      media_raddr = 8'h00;
      @(negedge clk);
      chk(media_rdata, {exp_tag, 8'h00});
      media_raddr = 8'hFF;
      @(negedge clk);
      chk(media_rdata, {exp_tag, 8'hFF});
      done_n++;
      media_err = done_n == err_at;
      media_done = 1'b1;
      @(negedge clk);
      media_done = 1'b0;
      media_err = 1'b0;
    end
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      mismatches++;
      $display("BAD t=%0t seen=%0h exp=%0h", $time, seen, exp);
    end
  endtask

  task automatic end_of_test();
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  task automatic setup(input logic [7:0] c, input logic [27:0] a,
                       input logic lba);
    host.wr(3'h2, {8'h00, c});
    host.wr(3'h3, {8'h00, a[7:0]});
    host.wr(3'h4, {8'h00, a[15:8]});
    host.wr(3'h5, {8'h00, a[23:16]});
    host.wr(3'h6, {8'h00, 1'b1, lba, 2'b10, a[27:24]});
  endtask

  // one sector; irq 2 means do not judge the interrupt
  task automatic xfer(input logic [7:0] g, input logic [27:0] a,
                      input int irq);
    logic q;
    int   d0, n;
    exp_tag = g;
    exp_addr = a;
    d0 = done_n;
    n = 0;
    host.sector(g, ok, q);
    if (irq < 2) chk(q, irq);
    // keep expectations until the media has taken this sector
    while (done_n == d0 && n < 2000) begin
      @(negedge clk);
      n++;
    end
    chk(ok && n < 2000, 1'b1);
  endtask

  // wait for the closing interrupt, read error and status
  task automatic finish(input logic [7:0] e);
    int n;
    n = 0;
    while (!(intrq === 1'b1 && busy === 1'b0) && n < 3000) begin
      @(negedge clk);
      n++;
    end
    chk({busy, drq, n < 3000}, 3'b001);
    host.rd(3'h1, rv);
    chk(rv, e);
    host.rd(3'h7, rv);
    chk({rv[7], rv[3], rv[0]}, {2'b00, e != 0});
  endtask

  task automatic t_chs();
    setup(8'h02, 28'h000053F, 1'b0);
    host.wr(3'h7, 16'h0030);
    xfer(8'h11, 28'h000053F, 0);
    xfer(8'h12, 28'h1000501, 1);
    finish(8'h00);
    host.rd(3'h2, rv);
    chk(rv, 16'h0000);
    host.rd(3'h6, rv);
    chk(rv, 16'h00A1);
    $display("chs write done");
  endtask

  task automatic t_zero_err();
    setup(8'h00, 28'h200FFFF, 1'b1);
    host.wr(3'h6, 16'h00F2); // drive 1 selected
    err_at = done_n + 2;
    host.wr(3'h7, 16'h0031);
    xfer(8'h21, 28'h200FFFF, 0);
    xfer(8'h22, 28'h2010000, 1);
    finish(8'h40);
    chk(media_lba_mode, 1'b1);
    chk(media_drive, 1'b1);
    host.rd(3'h2, rv);
    chk(rv, 16'h00FF);
    host.rd(3'h5, rv);
    chk(rv, 16'h0001);
    $display("zero count error done");
  endtask

  task automatic t_modes();
    logic [7:0] op [4] = '{8'h38, 8'h38, 8'h3C, 8'h31};
    logic       bl [4] = '{1'b1, 1'b0, 1'b1, 1'b1};
    logic [1:0] ex;
    foreach (op[i]) begin
      media_blank = bl[i];
      setup(8'h01, 28'h0000101, 1'b0);
      host.wr(3'h7, {8'h00, op[i]});
      xfer({4'h3, i[3:0]}, 28'h0000101, 0);
      finish(8'h00);
      ex = {!(op[i] == 8'h38 && bl[i]), op[i] == 8'h3C};
      chk({media_erase, media_verify}, ex);
    end
    $display("write modes done");
  endtask

  task automatic t_multi();
    host.wr(3'h7, 16'h00CD);
    finish(8'h04);
    setup(8'h02, 28'h0000101, 1'b0);
    host.wr(3'h7, 16'h00C6);
    finish(8'h04);
    host.wr(3'h2, 16'h0001);
    host.wr(3'h7, 16'h00C6);
    finish(8'h00);
    setup(8'h02, 28'h0000101, 1'b0);
    host.wr(3'h7, 16'h00CD);
    chk(busy, 1'b1);
    xfer(8'h41, 28'h0000101, 2);
    xfer(8'h42, 28'h0000102, 1);
    finish(8'h00);
    chk(media_erase, 1'b0);
    $display("block write done");
  endtask

  task automatic t_smart();
    logic [7:0] f [7] = '{8'hD0, 8'hD1, 8'hD2, 8'hD8, 8'hDA, 8'hD9, 8'hD3};
    foreach (f[i]) begin
      host.wr(3'h1, {8'h00, f[i]});
      host.wr(3'h7, 16'h00B0);
      finish(f[i] == 8'hD3 ? 8'h04 : 8'h00);
      if (f[i] inside {8'hD8, 8'hD9}) chk(smart_enabled, f[i] == 8'hD8);
    end
    $display("smart done");
  endtask

  // reset, then the scenarios
  initial begin
    rst_n = 1'b0;
    media_blank = 1'b1;
    media_done = 1'b0;
    media_err = 1'b0;
    media_raddr = 8'hFF;
    repeat (4) @(negedge clk);
    rst_n = 1'b1;
    host.rd(3'h7, rv);
    chk(rv, 16'h0050);
    t_chs();
    t_zero_err();
    t_modes();
    t_multi();
    t_smart();
    end_of_test();
  end
endmodule // awh_write_handler_bench

`default_nettype wire
